// *** rtl/eeprom_pkg.sv ***
/*
 * Shared constants and state types for the serial EEPROM command engine.
 * Assumes a 50 MHz system clock and a host-driven shift clock on the link.
 */
package eeprom_pkg;
    // ------------------------------------------------------------
    // array shape
    // ------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam int OP_W   = 2;

    // ------------------------------------------------------------
    // opcode table; extended forms use the top two address bits
    // ------------------------------------------------------------
    localparam logic [1:0] OP_READ        = 2'h2;
    localparam logic [1:0] OP_WRITE       = 2'h1;
    localparam logic [1:0] OP_ERASE       = 2'h3;
    localparam logic [1:0] OP_EXT         = 2'h0;
    localparam logic [1:0] SUB_DISABLE    = 2'h0;
    localparam logic [1:0] SUB_FILL_ALL   = 2'h1;
    localparam logic [1:0] SUB_CLEAR_ALL  = 2'h2;
    localparam logic [1:0] SUB_ENABLE     = 2'h3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int TEW_MS      = 5;
    localparam int SYS_CLK_MHZ = 50;
    localparam int PROG_CYCLES = TEW_MS * 1000 * SYS_CLK_MHZ;

    // ------------------------------------------------------------
    // state types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        L_START, L_OP, L_ADDR, L_DATA, L_READ, L_DONE
    } link_state_type;

    typedef enum logic [1:0] {
        S_IDLE, S_CLEAR, S_STORE
    } seq_state_type;
endpackage : eeprom_pkg

// *** rtl/pin_sync.sv ***
/*
 * Three-stage synchroniser with agreement filter, one per bit.
 * Assumes inputs may change at any time relative to clk.
 */
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // a bit moves only once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= (s2_r & s3_r) | (q & (s2_r ^ s3_r));
        end
    end
endmodule : pin_sync
`default_nettype wire

// *** rtl/serial_eeprom_command_engine.sv ***
/*
 * Command engine of a serial EEPROM: link shifter on shift_clock,
 * array and self-timed program sequencer on sys_clk.
 * Assumes the host drives select, shift_clock and serial_in, and
 * resolves the serial output pin from serial_out and serial_out_oe.
 */
// Behaviour
// - read: after address, output leaves high-z, sends zero, then word MSB first
// - read bits change on rising shift clock, stable until next rising edge
// - with select held and clock running, address increments and next word follows
// - sequential read wraps from top address to location zero
// - only the first word of a read stream has the leading zero
// - select falling after write starts self-timed clear then store
// - self-timed cycles finish without further shift clock edges
// - host may reselect during a cycle; device drives status on output
// - write clears its location itself before storing
// - erase on select fall clears the addressed location to all ones
// - power-up leaves programming disabled
// - enable command must precede program operations; otherwise ignored
// - enable persists across instructions until reset or disable command
// - while disabled, every write and clear form is rejected
// - reads work the same whether programming is enabled or not
// - clear-all on select fall sets every bit of the array to one
// - fill-all on select fall writes data word into every location
// - select must fall between last data bit and next rising edge
// - serial input sampled on the rising shift clock edge
// - instruction is start one, opcode, address, then data for writes
// - status polling drives low while busy, high when ready
// - a one shifted in while selected floats output on next falling edge
`timescale 1ns/1ns
`default_nettype none
module serial_eeprom_command_engine #(
    parameter int ADDR_W      = eeprom_pkg::ADDR_W,
    parameter int DATA_W      = eeprom_pkg::DATA_W,
    parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic shift_clock,
    input  wire logic select,
    input  wire logic serial_in,
    output var  logic serial_out,
    output var  logic serial_out_oe
);
    localparam int DEPTH = 2 ** ADDR_W;
    localparam int CW    = $clog2(DATA_W + ADDR_W + 1);
    localparam int TW    = $clog2(PROG_CYCLES + 1);
    localparam logic [TW-1:0] PHASE_LAST = TW'(PROG_CYCLES / 2 - 1);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic takes_data(input logic [1:0] op,
                                        input logic [1:0] sub);
        return op == eeprom_pkg::OP_WRITE ||
               (op == eeprom_pkg::OP_EXT && sub == eeprom_pkg::SUB_FILL_ALL);
    endfunction : takes_data

    // ------------------------------------------------------------
    // storage and cross-domain wires
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem_r [DEPTH];
    logic              busy_r;
    logic              busy_l;
    logic              link_rst_n;

    // link state is ended by the frame itself, not by a clock edge
    assign link_rst_n = rstn & select;

    // ------------------------------------------------------------
    // link domain: instruction shifter
    // ------------------------------------------------------------
    eeprom_pkg::link_state_type lst_r;
    logic [CW-1:0]     lcnt_r;
    logic [1:0]        cap_op_r;
    logic [ADDR_W-1:0] cap_addr_r;
    logic [DATA_W-1:0] cap_data_r;
    logic [ADDR_W-1:0] addr_nxt;
    logic [1:0]        sub_nxt;
    logic              addr_last;
    logic              data_last;
    logic              rd_last;
    logic              is_read;
    logic              done_edge;

    assign addr_nxt  = {cap_addr_r[ADDR_W-2:0], serial_in};
    assign sub_nxt   = addr_nxt[ADDR_W-1 -: 2];
    assign addr_last = lst_r == eeprom_pkg::L_ADDR && lcnt_r == CW'(ADDR_W - 1);
    assign data_last = lst_r == eeprom_pkg::L_DATA && lcnt_r == CW'(DATA_W - 1);
    assign rd_last   = lcnt_r == CW'(DATA_W - 1);
    assign is_read   = cap_op_r == eeprom_pkg::OP_READ;
    assign done_edge = (addr_last && !is_read && !takes_data(cap_op_r, sub_nxt)) ||
                       data_last;

    pin_sync #(.W(1)) u_busy_sync (
        .clk   (shift_clock),
        .rst_n (link_rst_n), // link clock stops between frames, so a stale busy view must not outlive one
        .d     (busy_r),
        .q     (busy_l)
    );

    always_ff @(posedge shift_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            lst_r  <= eeprom_pkg::L_START;
            lcnt_r <= '0;
        end else begin
            unique case (lst_r)
                eeprom_pkg::L_START: begin
                    // leading zeros are skipped; busy holds the shifter idle
                    if (serial_in && !busy_l) begin
                        lst_r  <= eeprom_pkg::L_OP;
                        lcnt_r <= '0;
                    end
                end
                eeprom_pkg::L_OP: begin
                    if (lcnt_r == CW'(eeprom_pkg::OP_W - 1)) begin
                        lst_r  <= eeprom_pkg::L_ADDR;
                        lcnt_r <= '0;
                    end else begin
                        lcnt_r <= lcnt_r + 1'b1;
                    end
                end
                eeprom_pkg::L_ADDR: begin
                    if (addr_last) begin
                        lcnt_r <= '0;
                        if (is_read) begin
                            lst_r <= eeprom_pkg::L_READ;
                        end else if (takes_data(cap_op_r, sub_nxt)) begin
                            lst_r <= eeprom_pkg::L_DATA;
                        end else begin
                            lst_r <= eeprom_pkg::L_DONE;
                        end
                    end else begin
                        lcnt_r <= lcnt_r + 1'b1;
                    end
                end
                eeprom_pkg::L_DATA: begin
                    if (data_last) begin
                        lst_r <= eeprom_pkg::L_DONE;
                    end else begin
                        lcnt_r <= lcnt_r + 1'b1;
                    end
                end
                eeprom_pkg::L_READ: begin
                    lcnt_r <= rd_last ? '0 : lcnt_r + 1'b1;
                end
                eeprom_pkg::L_DONE: begin
                    lst_r <= eeprom_pkg::L_DONE;
                end
            endcase
        end
    end

    // captured fields survive select low so the sequencer can read them
    always_ff @(posedge shift_clock or negedge rstn) begin
        if (!rstn) begin
            cap_op_r   <= '0;
            cap_addr_r <= '0;
            cap_data_r <= '0;
        end else begin
            if (select && lst_r == eeprom_pkg::L_OP) begin
                cap_op_r <= {cap_op_r[0], serial_in};
            end
            if (select && lst_r == eeprom_pkg::L_ADDR) begin
                cap_addr_r <= addr_nxt;
            end
            if (select && lst_r == eeprom_pkg::L_DATA) begin
                cap_data_r <= {cap_data_r[DATA_W-2:0], serial_in};
            end
        end
    end

    // completion marker; any further edge revokes it
    logic seq_l_r;
    logic full_l_r;

    always_ff @(posedge shift_clock or negedge rstn) begin
        if (!rstn) begin
            seq_l_r  <= 1'b0;
            full_l_r <= 1'b0;
        end else begin
            full_l_r <= select && done_edge;
            if (select && done_edge) begin
                seq_l_r <= ~seq_l_r;
            end
        end
    end

    // ------------------------------------------------------------
    // link domain: read streaming
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] rd_addr_r;
    logic [DATA_W-1:0] rd_sh_r;
    logic              dout_l_r;
    logic              doe_l_r;
    logic              one_l_r;
    logic              hz_l_r;

    // the array only changes in self-timed cycles, when reads are refused
    always_ff @(posedge shift_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rd_addr_r <= '0;
            rd_sh_r   <= '0;
            dout_l_r  <= 1'b0;
            doe_l_r   <= 1'b0;
        end else if (addr_last && is_read) begin
            doe_l_r   <= 1'b1;
            dout_l_r  <= 1'b0;
            rd_addr_r <= addr_nxt;
            rd_sh_r   <= mem_r[addr_nxt];
        end else if (lst_r == eeprom_pkg::L_READ) begin
            dout_l_r <= rd_sh_r[DATA_W-1];
            if (rd_last) begin
                rd_addr_r <= rd_addr_r + 1'b1;
                rd_sh_r   <= mem_r[ADDR_W'(rd_addr_r + 1'b1)];
            end else begin
                rd_sh_r <= {rd_sh_r[DATA_W-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge shift_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            one_l_r <= 1'b0;
        end else if (lst_r == eeprom_pkg::L_START && serial_in) begin
            one_l_r <= 1'b1;
        end
    end

    always_ff @(negedge shift_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            hz_l_r <= 1'b0;
        end else begin
            hz_l_r <= one_l_r;
        end
    end

    // ------------------------------------------------------------
    // system domain: crossing and command pickup
    // ------------------------------------------------------------
    logic sel_s;
    logic seq_s;
    logic full_s;
    logic dout_s;
    logic doe_s;
    logic hz_s;
    logic sel_d_r;
    logic last_seq_r;
    logic sel_fall;
    logic new_cmd;
    logic is_ext;
    logic [1:0] sub_cap;
    logic prog_cmd;
    logic go;
    logic prog_en_r;
    logic poll_en_r;

    pin_sync #(.W(6)) u_link_sync (
        .clk   (sys_clk),
        .rst_n (rstn),
        .d     ({select, seq_l_r, full_l_r, dout_l_r, doe_l_r, hz_l_r}),
        .q     ({sel_s, seq_s, full_s, dout_s, doe_s, hz_s})
    );

    assign sel_fall = sel_d_r && !sel_s;
    assign new_cmd  = sel_fall && (seq_s != last_seq_r) && full_s;
    assign is_ext   = cap_op_r == eeprom_pkg::OP_EXT;
    assign sub_cap  = cap_addr_r[ADDR_W-1 -: 2];
    assign prog_cmd = cap_op_r == eeprom_pkg::OP_WRITE ||
                      cap_op_r == eeprom_pkg::OP_ERASE ||
                      (is_ext && (sub_cap == eeprom_pkg::SUB_FILL_ALL ||
                                  sub_cap == eeprom_pkg::SUB_CLEAR_ALL));
    assign go       = new_cmd && !busy_r && prog_en_r && prog_cmd;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sel_d_r    <= 1'b0;
            last_seq_r <= 1'b0;
        end else begin
            sel_d_r <= sel_s;
            if (sel_fall) begin
                last_seq_r <= seq_s; // a clockless frame cannot replay a command
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prog_en_r <= 1'b0;
        end else if (new_cmd && !busy_r && is_ext) begin
            if (sub_cap == eeprom_pkg::SUB_ENABLE) begin
                prog_en_r <= 1'b1;
            end else if (sub_cap == eeprom_pkg::SUB_DISABLE) begin
                prog_en_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // system domain: self-timed clear and store
    // ------------------------------------------------------------
    eeprom_pkg::seq_state_type st_r;
    logic [TW-1:0]     tmr_r;
    logic [ADDR_W-1:0] op_addr_r;
    logic [DATA_W-1:0] op_data_r;
    logic              op_all_r;
    logic              op_clr_r;
    logic              op_store_r;
    logic              phase_end;
    logic              clr_hit;
    logic              store_hit;

    assign phase_end = tmr_r == PHASE_LAST;
    assign clr_hit   = st_r == eeprom_pkg::S_CLEAR && phase_end && op_clr_r;
    assign store_hit = st_r == eeprom_pkg::S_STORE && phase_end && op_store_r;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_r       <= eeprom_pkg::S_IDLE;
            tmr_r      <= '0;
            op_addr_r  <= '0;
            op_data_r  <= '0;
            op_all_r   <= 1'b0;
            op_clr_r   <= 1'b0;
            op_store_r <= 1'b0;
        end else begin
            unique case (st_r)
                eeprom_pkg::S_IDLE: begin
                    if (go) begin
                        st_r       <= eeprom_pkg::S_CLEAR;
                        tmr_r      <= '0;
                        op_addr_r  <= cap_addr_r;
                        op_data_r  <= cap_data_r;
                        op_all_r   <= is_ext;
                        // fill-all needs no clear; write clears itself
                        op_clr_r   <= !(is_ext && sub_cap == eeprom_pkg::SUB_FILL_ALL);
                        op_store_r <= takes_data(cap_op_r, sub_cap);
                    end
                end
                eeprom_pkg::S_CLEAR: begin
                    // runs on sys_clk alone, no shift edges needed
                    tmr_r <= phase_end ? '0 : tmr_r + 1'b1;
                    if (phase_end) begin
                        st_r <= eeprom_pkg::S_STORE;
                    end
                end
                eeprom_pkg::S_STORE: begin
                    tmr_r <= phase_end ? '0 : tmr_r + 1'b1;
                    if (phase_end) begin
                        st_r <= eeprom_pkg::S_IDLE;
                    end
                end
            endcase
        end
    end

    assign busy_r = st_r != eeprom_pkg::S_IDLE;

    // array powers up erased; it is not a model of retention
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '1;
            end
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                if (clr_hit && (op_all_r || op_addr_r == ADDR_W'(i))) begin
                    mem_r[i] <= '1;
                end else if (store_hit && (op_all_r || op_addr_r == ADDR_W'(i))) begin
                    mem_r[i] <= op_data_r;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // system domain: serial output pin
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            poll_en_r <= 1'b0;
        end else if (go) begin
            poll_en_r <= 1'b1;
        end else if (hz_s && sel_s && sel_d_r) begin
            poll_en_r <= 1'b0;
        end
    end

    // read data is masked while busy, so a stale busy view in the link is harmless
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            serial_out    <= 1'b0;
            serial_out_oe <= 1'b0;
        end else begin
            serial_out_oe <= sel_s && ((doe_s && !busy_r) || (poll_en_r && !hz_s));
            serial_out    <= (doe_s && !busy_r) ? dout_s : !busy_r;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_disabled_reject: assert property (@(posedge sys_clk) disable iff (!rstn)
        (new_cmd && prog_cmd && !prog_en_r && !busy_r) |=> st_r == eeprom_pkg::S_IDLE)
        else $error("program op accepted while disabled");

    a_fall_starts: assert property (@(posedge sys_clk) disable iff (!rstn)
        (new_cmd && prog_cmd && prog_en_r && !busy_r) |=> st_r == eeprom_pkg::S_CLEAR && tmr_r == '0)
        else $error("self-timed cycle did not start on select fall");

    a_phase_advance: assert property (@(posedge sys_clk) disable iff (!rstn)
        (st_r == eeprom_pkg::S_CLEAR && phase_end) |=> st_r == eeprom_pkg::S_STORE ##1 busy_r)
        else $error("clear phase did not hand over to store");

    a_clear_ones: assert property (@(posedge sys_clk) disable iff (!rstn)
        (clr_hit && !op_all_r) |=> mem_r[op_addr_r] == '1)
        else $error("cleared location not all ones");

    a_fill_every: assert property (@(posedge sys_clk) disable iff (!rstn)
        (store_hit && op_all_r) |=> mem_r[0] == op_data_r && mem_r[DEPTH-1] == op_data_r)
        else $error("fill-all missed a location");

    a_status_busy: assert property (@(posedge sys_clk) disable iff (!rstn)
        (busy_r && sel_s && poll_en_r && !hz_s) |=> serial_out_oe && !serial_out)
        else $error("busy status not driven low");

    a_enable_holds: assert property (@(posedge sys_clk) disable iff (!rstn)
        (prog_en_r && !(new_cmd && is_ext && sub_cap == eeprom_pkg::SUB_DISABLE)) |=> prog_en_r)
        else $error("programming enable dropped without disable");

    a_busy_ignore: assert property (@(posedge sys_clk) disable iff (!rstn)
        (busy_r && sel_fall) |=> $stable(prog_en_r) && $stable(op_addr_r))
        else $error("instruction acted on while busy");

    a_lead_zero: assert property (@(posedge shift_clock) disable iff (!link_rst_n)
        (addr_last && is_read) |=> doe_l_r && !dout_l_r ##1 lst_r == eeprom_pkg::L_READ)
        else $error("read did not open with a zero bit");

    a_stream_next: assert property (@(posedge shift_clock) disable iff (!link_rst_n)
        (lst_r == eeprom_pkg::L_READ && rd_last) |=> rd_addr_r == ADDR_W'($past(rd_addr_r) + 1'b1))
        else $error("read stream did not advance address");

    c_write_cycle: cover property (@(posedge sys_clk) disable iff (!rstn)
        go ##1 st_r == eeprom_pkg::S_CLEAR);
    c_read_wrap: cover property (@(posedge shift_clock) disable iff (!link_rst_n)
        lst_r == eeprom_pkg::L_READ && rd_last && rd_addr_r == '1);
    c_fill_all: cover property (@(posedge sys_clk) disable iff (!rstn)
        store_hit && op_all_r);
    c_poll_busy: cover property (@(posedge sys_clk) disable iff (!rstn)
        busy_r && serial_out_oe);
endmodule : serial_eeprom_command_engine
`default_nettype wire

// *** tb/host_model.sv ***
/* host side of the link: shifts frames, samples the serial output.
   assumes the engine pins are wired straight to it, no pulls. */
`timescale 1ns/1ns
`default_nettype none
module host_model (
    output var  logic shift_clock,
    output var  logic select,
    output var  logic serial_in,
    input  wire logic serial_out,
    input  wire logic serial_out_oe
);
    // ----
    // frame drivers
    // ----
    logic [63:0] got;
    initial begin
        {shift_clock, select, serial_in, got} = '0;
    end
    // data set while low, sampled just before the rise
    task automatic tick(input logic b);
        serial_in = b;
        #80 got = {got[62:0], serial_out_oe ? serial_out : 1'bz};
        shift_clock = 1'b1;
        #80 shift_clock = 1'b0;
    endtask : tick
    // start bit first, fields msb first
    task automatic xfer(input logic [24:0] b, input int n, input int extra);
        select = 1'b1;
        for (int i = n - 1; i >= 0; i--) tick(b[i]);
        for (int i = 0; i < extra; i++) tick(1'b0);
        select = 1'b0; // before the next rise
        serial_in = ~serial_in;
        #1000; // select low time
    endtask : xfer
    // reselect to read status
    task automatic poll(output logic s);
        select = 1'b1;
        #200 s = serial_out_oe ? serial_out : 1'bz;
    endtask : poll
    task automatic drop;
        select = 1'b0;
        #1000;
    endtask : drop
endmodule : host_model
`default_nettype wire

// *** tb/tb.sv ***
/* bench: table of program ops each read back, then wrap, window, busy.
   assumes host_model drives the link; short program count. */
`timescale 1ns/1ns
`default_nettype none
module tb;
    // ----
    // rows and helpers
    // ----
    typedef struct packed {
        logic [24:0] b;
        logic [5:0]  a;
        logic [15:0] d;
    } row_type;
    logic      sys_clk;
    logic      rstn;
    logic      s;
    wire logic shift_clock, select, serial_in, serial_out, serial_out_oe;
    int        miscompares = 0;
    int        n_tests = 0;
    function automatic logic [24:0] w(input logic [5:0] a, input logic [15:0] d);
        return {1'b1, eeprom_pkg::OP_WRITE, a, d};
    endfunction : w
    function automatic logic [24:0] x(input logic [1:0] sub);
        return {16'h0, 1'b1, eeprom_pkg::OP_EXT, sub, 4'h0};
    endfunction : x
    row_type rows [11] = '{
        '{w(6'h05, 16'h1234), 6'h05, 16'hffff},
        '{x(eeprom_pkg::SUB_ENABLE), 6'h05, 16'hffff},
        '{w(6'h05, 16'h1234), 6'h05, 16'h1234},
        '{w(6'h05, 16'ha5c3), 6'h05, 16'ha5c3},
        '{{16'h0, 1'b1, eeprom_pkg::OP_ERASE, 6'h05}, 6'h05, 16'hffff},
        '{{1'b1, eeprom_pkg::OP_EXT, eeprom_pkg::SUB_FILL_ALL, 4'h0, 16'h0f0f}, 6'h3f, 16'h0f0f},
        '{x(eeprom_pkg::SUB_CLEAR_ALL), 6'h3f, 16'hffff},
        '{w(6'h3f, 16'hbeef), 6'h3f, 16'hbeef},
        '{x(eeprom_pkg::SUB_DISABLE), 6'h3f, 16'hbeef},
        '{w(6'h3f, 16'h0000), 6'h3f, 16'hbeef},
        '{x(eeprom_pkg::SUB_CLEAR_ALL), 6'h3f, 16'hbeef}
    };
    serial_eeprom_command_engine #(.PROG_CYCLES(1000)) uut (
        .sys_clk(sys_clk), .rstn(rstn), .shift_clock(shift_clock), .select(select),
        .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe));
    host_model host (.shift_clock(shift_clock), .select(select), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe));
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [5:0] a);
        host.xfer({16'h0, 1'b1, eeprom_pkg::OP_READ, a}, 9, 33);
    endtask : rd
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict
    // ----
    // sequence
    // ----
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        #1000000 miscompares++;
        give_verdict();
    end
    initial begin
        rstn = 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        #203; // link edges kept off sys_clk edges, so no sample races an update
        foreach (rows[i]) begin
            host.xfer(rows[i].b, rows[i].b[24] ? 25 : 9, 0);
            #25000 rd(rows[i].a);
            chk(host.got[32:16], {1'b0, rows[i].d});
        end
        rd(6'h3f);
        chk({1'b0, host.got[15:0]}, 17'h0ffff);
        host.xfer(x(eeprom_pkg::SUB_ENABLE), 9, 0);
        host.xfer(w(6'h01, 16'h0bad), 25, 1); // late select drop cancels
        host.xfer(w(6'h00, 16'h1357), 25, 0);
        host.poll(s);
        chk({16'h0, s}, 17'h0);
        host.drop();
        #25000 host.poll(s);
        chk({16'h0, s}, 17'h1);
        host.tick(1'b1);
        #200 chk({16'h0, serial_out_oe}, 17'h0);
        host.drop();
        host.xfer(w(6'h03, 16'h5555), 25, 0);
        host.xfer(w(6'h02, 16'h2468), 25, 0); // ignored while busy
        #25000 rd(6'h00);
        chk(host.got[32:16], 17'h01357);
        chk({1'b0, host.got[15:0]}, 17'h0ffff);
        rd(6'h02);
        chk(host.got[32:16], 17'h0ffff);
        chk({1'b0, host.got[15:0]}, 17'h05555);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
